// file: design/radio_cfg_regs.sv
// modem configuration bank: filter bandwidth, modulation, frequency correction
// assumes: axi4-lite master on aclk; detector pulses come from logic on aclk
`timescale 1ns/10ps
`default_nettype none
`include "radio_cfg_consts.svh"

module radio_cfg_regs
   import radio_cfg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic preamble_found,
   input wire logic sync_found,
   input wire logic preamble_match_zero,
   input wire logic rx_restart,
   output logic [8:0] if_bw_khz,
   output logic [8:0] if_freq_khz,
   output logic tx_fsk,
   output logic tx_gfsk,
   output logic tx_ook,
   output logic tx_carrier,
   output logic tx_mod_reserved,
   output logic rx_fsk,
   output logic rx_ook,
   output logic rx_demod_reserved,
   output logic freq_corr_enable,
   output logic freq_corr_update,
   output logic freq_corr_frozen,
   output loop_gain_t freq_corr_gain,
   output loop_gain_t ook_thresh_gain
);

   // ------------------------------------------------------------
   // storage and internal signals
   // ------------------------------------------------------------
   bw_mod_cfg_t bw_mod;
   corr_mode_cfg_t corr_mode;
   corr_gain_cfg_t corr_gain;
   corr_state_t corr_state;
   corr_state_t next_corr_state;
   logic aw_held;
   logic w_held;
   logic [11:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;
   logic do_write;
   logic [15:0] prop_gain;
   logic [15:0] int_gain;
   logic ook_sel;
   logic [7:0] status;
   logic [31:0] read_word;
   logic read_hit;

   // ------------------------------------------------------------
   // write channels: address and data taken in either order
   // ------------------------------------------------------------
   assign do_write = aw_held && w_held && !bvalid;

   // write address acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_held <= 1'b1;
         aw_addr <= awaddr;
      end else begin
         if (do_write) begin
            aw_held <= 1'b0;
         end
         awready <= !aw_held && !bvalid;
      end
   end

   // write data acceptance, only byte lane 0 carries a register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b0;
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_held <= 1'b1;
         w_byte <= wdata[7:0];
         w_lane0 <= wstrb[0];
      end else begin
         if (do_write) begin
            w_held <= 1'b0;
         end
         wready <= !w_held && !bvalid;
      end
   end

   // write response, slverr on an unmapped address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         case (aw_addr)
            {`BW_MOD_IDX, `ADDR_LSB_ZERO},
            {`CORR_MODE_IDX, `ADDR_LSB_ZERO},
            {`CORR_GAIN_IDX, `ADDR_LSB_ZERO},
            {`CFG_STATUS_IDX, `ADDR_LSB_ZERO}: bresp <= `RESP_OKAY;
            default: bresp <= `RESP_SLVERR;
         endcase
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   // software writes land here; reserved codes are stored as written
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bw_mod <= `BW_MOD_RST;
         corr_mode <= `CORR_MODE_RST;
         corr_gain <= `CORR_GAIN_RST;
      end else if (do_write && w_lane0) begin
         if (aw_addr == {`BW_MOD_IDX, `ADDR_LSB_ZERO}) begin
            bw_mod <= w_byte;
         end
         if (aw_addr == {`CORR_MODE_IDX, `ADDR_LSB_ZERO}) begin
            corr_mode <= w_byte;
         end
         if (aw_addr == {`CORR_GAIN_IDX, `ADDR_LSB_ZERO}) begin
            corr_gain <= w_byte;
         end
      end
   end

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   // status word shows the block's own decoded state
   always_comb begin
      status = 8'h00;
      status[`ST_FROZEN] = freq_corr_frozen;
      status[`ST_IF_SHIFT] = (if_freq_khz == `KHZ_300);
      status[`ST_TX_RSVD] = tx_mod_reserved;
      status[`ST_RX_RSVD] = rx_demod_reserved;
      status[`ST_OOK] = ook_sel;
      status[`ST_FREE] = (corr_state == CORR_RUN);
   end

   // read mux
   always_comb begin
      read_word = 32'h0000_0000;
      read_hit = 1'b1;
      case (araddr)
         {`BW_MOD_IDX, `ADDR_LSB_ZERO}: read_word[7:0] = bw_mod;
         {`CORR_MODE_IDX, `ADDR_LSB_ZERO}: read_word[7:0] = corr_mode;
         {`CORR_GAIN_IDX, `ADDR_LSB_ZERO}: read_word[7:0] = corr_gain;
         {`CFG_STATUS_IDX, `ADDR_LSB_ZERO}: read_word[7:0] = status;
         default: read_hit = 1'b0;
      endcase
   end

   // read address acceptance and data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= read_word;
         rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else begin
         arready <= !rvalid;
      end
   end

   // ------------------------------------------------------------
   // filter bandwidth and intermediate frequency
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         if_bw_khz <= `KHZ_100;
         if_freq_khz <= `KHZ_200;
      end else begin
         unique case (bw_mod.if_filter_bw_sel)
            `IF_BW_100K: if_bw_khz <= `KHZ_100;
            `IF_BW_150K: if_bw_khz <= `KHZ_150;
            `IF_BW_200K: if_bw_khz <= `KHZ_200;
            `IF_BW_300K: if_bw_khz <= `KHZ_300;
         endcase
         // the widest filter needs the higher IF to keep the image clear
         if_freq_khz <= (bw_mod.if_filter_bw_sel == `IF_BW_300K) ? `KHZ_300 : `KHZ_200;
      end
   end

   // ------------------------------------------------------------
   // modulation and demodulation selects
   // ------------------------------------------------------------
   assign ook_sel = (bw_mod.rx_demodulation_sel == `RX_DEMOD_OOK);

   // one-hot scheme outputs; reserved codes raise the reserved flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_fsk <= 1'b1;
         tx_gfsk <= 1'b0;
         tx_ook <= 1'b0;
         tx_carrier <= 1'b0;
         tx_mod_reserved <= 1'b0;
         rx_fsk <= 1'b1;
         rx_ook <= 1'b0;
         rx_demod_reserved <= 1'b0;
      end else begin
         tx_fsk <= (bw_mod.tx_modulation_sel == `TX_MOD_FSK);
         tx_gfsk <= (bw_mod.tx_modulation_sel == `TX_MOD_GFSK);
         tx_ook <= (bw_mod.tx_modulation_sel == `TX_MOD_OOK);
         tx_carrier <= (bw_mod.tx_modulation_sel == `TX_MOD_CARRIER);
         tx_mod_reserved <= bw_mod.tx_modulation_sel[2];
         rx_fsk <= (bw_mod.rx_demodulation_sel == `RX_DEMOD_FSK);
         rx_ook <= ook_sel;
         rx_demod_reserved <= !ook_sel && (bw_mod.rx_demodulation_sel != `RX_DEMOD_FSK);
      end
   end

   // ------------------------------------------------------------
   // frequency correction loop control
   // ------------------------------------------------------------
   // next state from the lock field and the detector pulses
   always_comb begin
      next_corr_state = CORR_RUN;
      unique case (corr_mode.freq_corr_lock_sel)
         `LOCK_FREE: next_corr_state = CORR_RUN;
         `LOCK_DISABLED: next_corr_state = CORR_OFF;
         `LOCK_HOLD: next_corr_state = CORR_HOLD;
         `LOCK_ON_DETECT: begin
            // a freeze lasts until the receiver restarts its search
            if (corr_state == CORR_FROZEN && !rx_restart) begin
               next_corr_state = CORR_FROZEN;
            end else if (preamble_found || (sync_found && preamble_match_zero)) begin
               next_corr_state = CORR_FROZEN;
            end else begin
               next_corr_state = CORR_RUN;
            end
         end
      endcase
   end

   // state register and its flopped views
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         corr_state <= CORR_RUN;
         freq_corr_enable <= 1'b1;
         freq_corr_update <= 1'b1;
         freq_corr_frozen <= 1'b0;
      end else begin
         corr_state <= next_corr_state;
         freq_corr_enable <= (next_corr_state != CORR_OFF);
         freq_corr_update <= (next_corr_state == CORR_RUN);
         freq_corr_frozen <= (next_corr_state == CORR_FROZEN);
      end
   end

   // ------------------------------------------------------------
   // loop gains
   // ------------------------------------------------------------
   gain_decode prop_decode (
      .aclk(aclk),
      .aresetn(aresetn),
      .code(corr_gain.freq_corr_prop_gain),
      .gain(prop_gain)
   );

   gain_decode int_decode (
      .aclk(aclk),
      .aresetn(aresetn),
      .code(corr_gain.freq_corr_int_gain),
      .gain(int_gain)
   );

   // the gains feed one loop only; the idle loop sees zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         freq_corr_gain <= '0;
         ook_thresh_gain <= '0;
      end else if (ook_sel) begin
         freq_corr_gain <= '0;
         ook_thresh_gain.prop <= prop_gain;
         ook_thresh_gain.integ <= int_gain;
      end else begin
         freq_corr_gain.prop <= prop_gain;
         freq_corr_gain.integ <= int_gain;
         ook_thresh_gain <= '0;
      end
   end

endmodule : radio_cfg_regs

`default_nettype wire

// file: design/radio_cfg_consts.svh
// constants of the modem configuration register bank
// assumes: included by bare name from every design file that needs it
`ifndef RADIO_CFG_CONSTS_SVH
`define RADIO_CFG_CONSTS_SVH

// ------------------------------------------------------------
// register indices and byte addresses (byte address = 4 x index)
// ------------------------------------------------------------
`define BW_MOD_IDX 10'h115
`define CORR_MODE_IDX 10'h116
`define CORR_GAIN_IDX 10'h117
`define CFG_STATUS_IDX 10'h120
`define ADDR_LSB_ZERO 2'h0
`define AXI_ADDR_W 12

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define BW_MOD_RST 8'h00
`define CORR_MODE_RST 8'h08
`define CORR_GAIN_RST 8'h37

// ------------------------------------------------------------
// field codes
// ------------------------------------------------------------
`define IF_BW_100K 2'h0
`define IF_BW_150K 2'h1
`define IF_BW_200K 2'h2
`define IF_BW_300K 2'h3
`define TX_MOD_FSK 3'h0
`define TX_MOD_GFSK 3'h1
`define TX_MOD_OOK 3'h2
`define TX_MOD_CARRIER 3'h3
`define RX_DEMOD_FSK 3'h0
`define RX_DEMOD_OOK 3'h2
`define LOCK_FREE 2'h0
`define LOCK_DISABLED 2'h1
`define LOCK_HOLD 2'h2
`define LOCK_ON_DETECT 2'h3

// ------------------------------------------------------------
// frequencies in kHz
// ------------------------------------------------------------
`define KHZ_100 9'h064
`define KHZ_150 9'h096
`define KHZ_200 9'h0c8
`define KHZ_300 9'h12c

// ------------------------------------------------------------
// bus answers and status bit positions
// ------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ST_FROZEN 0
`define ST_IF_SHIFT 1
`define ST_TX_RSVD 2
`define ST_RX_RSVD 3
`define ST_OOK 4
`define ST_FREE 5

`endif

// file: design/radio_cfg_pkg.sv
// types of the modem configuration register bank
// assumes: the constants header is compiled alongside
package radio_cfg_pkg;

   // ------------------------------------------------------------
   // register layouts
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] if_filter_bw_sel;
      logic [2:0] tx_modulation_sel;
      logic [2:0] rx_demodulation_sel;
   } bw_mod_cfg_t;

   typedef struct packed {
      logic [2:0] reserved;
      logic freq_corr_polarity;
      logic [1:0] freq_corr_scheme;
      logic [1:0] freq_corr_lock_sel;
   } corr_mode_cfg_t;

   typedef struct packed {
      logic [3:0] freq_corr_prop_gain;
      logic [3:0] freq_corr_int_gain;
   } corr_gain_cfg_t;

   // proportional and integral gains of one pi loop
   typedef struct packed {
      logic [15:0] prop;
      logic [15:0] integ;
   } loop_gain_t;

   // frequency correction loop state
   typedef enum logic [3:0] {
      CORR_OFF = 4'b0001,
      CORR_RUN = 4'b0010,
      CORR_HOLD = 4'b0100,
      CORR_FROZEN = 4'b1000
   } corr_state_t;

endpackage : radio_cfg_pkg

// file: design/gain_decode.sv
// turns a four-bit exponent field into a power-of-two gain
// assumes: code comes from a register on the same clock
`timescale 1ns/10ps
`default_nettype none

module gain_decode (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] code,
   output logic [15:0] gain
);

   // ------------------------------------------------------------
   // registered decode: gain = 2 ** code
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gain <= 16'h0001;
      end else begin
         gain <= 16'h0001 << code;
      end
   end

endmodule : gain_decode

`default_nettype wire

// file: verification/radio_cfg_checker.sv
// checker for the modem configuration bank: decode, freeze and gain relations
// assumes: bound to radio_cfg_regs, one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
`include "radio_cfg_consts.svh"

module radio_cfg_checker
   import radio_cfg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic preamble_found,
   input wire logic sync_found,
   input wire logic preamble_match_zero,
   input wire logic [8:0] if_bw_khz,
   input wire logic [8:0] if_freq_khz,
   input wire logic tx_fsk,
   input wire logic tx_gfsk,
   input wire logic tx_ook,
   input wire logic tx_carrier,
   input wire logic tx_mod_reserved,
   input wire logic rx_fsk,
   input wire logic rx_ook,
   input wire logic rx_demod_reserved,
   input wire logic freq_corr_enable,
   input wire logic freq_corr_update,
   input wire logic freq_corr_frozen,
   input wire loop_gain_t freq_corr_gain,
   input wire loop_gain_t ook_thresh_gain
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ------------------------------------------------------------
   // decode relations
   // ------------------------------------------------------------
   property p_bw_code; if_bw_khz inside {`KHZ_100, `KHZ_150, `KHZ_200, `KHZ_300}; endproperty
   a_bw_code: assert property (p_bw_code) else $error("bandwidth off its table");
   property p_if_shift; if_freq_khz == ((if_bw_khz == `KHZ_300) ? `KHZ_300 : `KHZ_200); endproperty
   a_if_shift: assert property (p_if_shift) else $error("if frequency not tied to bandwidth");
   property p_tx_dec; $onehot({tx_fsk, tx_gfsk, tx_ook, tx_carrier, tx_mod_reserved}); endproperty
   a_tx_dec: assert property (p_tx_dec) else $error("tx decode not one-hot");
   property p_rx_dec; $onehot({rx_fsk, rx_ook, rx_demod_reserved}); endproperty
   a_rx_dec: assert property (p_rx_dec) else $error("rx decode not one-hot");

   // ------------------------------------------------------------
   // correction loop mode and freeze
   // ------------------------------------------------------------
   property p_frozen_out; freq_corr_frozen [*2] |-> freq_corr_enable && !freq_corr_update; endproperty
   a_frozen_out: assert property (p_frozen_out) else $error("frozen loop still tracking");
   property p_freeze_cause;
      $rose(freq_corr_frozen) |-> $past(preamble_found) || ($past(sync_found) && $past(preamble_match_zero));
   endproperty
   a_freeze_cause: assert property (p_freeze_cause) else $error("freeze without a valid detect");

   // ------------------------------------------------------------
   // gain steering, settled values only
   // ------------------------------------------------------------
   property p_fsk_gain;
      (!rx_ook) [*4] |-> $onehot(freq_corr_gain.prop) && $onehot(freq_corr_gain.integ) && ook_thresh_gain == '0;
   endproperty
   a_fsk_gain: assert property (p_fsk_gain) else $error("correction gains not powers of two");
   property p_ook_gain;
      rx_ook [*4] |-> freq_corr_gain == '0 && $onehot(ook_thresh_gain.prop) && $onehot(ook_thresh_gain.integ);
   endproperty
   a_ook_gain: assert property (p_ook_gain) else $error("threshold loop gains not steered");

   c_frozen: cover property ($rose(freq_corr_frozen));
   c_ook: cover property (rx_ook [*4]);
   c_if_shift: cover property (if_freq_khz == `KHZ_300);
endmodule : radio_cfg_checker

bind radio_cfg_regs radio_cfg_checker i_radio_cfg_checker (.aclk(aclk), .aresetn(aresetn),
   .preamble_found(preamble_found), .sync_found(sync_found), .preamble_match_zero(preamble_match_zero),
   .if_bw_khz(if_bw_khz), .if_freq_khz(if_freq_khz), .tx_fsk(tx_fsk), .tx_gfsk(tx_gfsk), .tx_ook(tx_ook),
   .tx_carrier(tx_carrier), .tx_mod_reserved(tx_mod_reserved), .rx_fsk(rx_fsk), .rx_ook(rx_ook),
   .rx_demod_reserved(rx_demod_reserved), .freq_corr_enable(freq_corr_enable),
   .freq_corr_update(freq_corr_update), .freq_corr_frozen(freq_corr_frozen),
   .freq_corr_gain(freq_corr_gain), .ook_thresh_gain(ook_thresh_gain));

`default_nettype wire

// file: verification/tb_radio_modem_afc_config_regs.sv
// self-checking bench for the modem configuration bank over axi4-lite
// assumes: design files and checker compiled first; 125 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "radio_cfg_consts.svh"

module tb_radio_modem_afc_config_regs
   import radio_cfg_pkg::*;
;
   localparam logic [11:0] A_BW = {`BW_MOD_IDX, `ADDR_LSB_ZERO};
   localparam logic [11:0] A_MODE = {`CORR_MODE_IDX, `ADDR_LSB_ZERO};
   localparam logic [11:0] A_GAIN = {`CORR_GAIN_IDX, `ADDR_LSB_ZERO};
   localparam logic [11:0] A_STAT = {`CFG_STATUS_IDX, `ADDR_LSB_ZERO};
   logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
   logic rready = 1'h0, preamble_found = 1'h0, sync_found = 1'h0, preamble_match_zero = 1'h0, rx_restart = 1'h0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [8:0] if_bw_khz, if_freq_khz;
   // bits driven by separate output ports, so nets rather than variables
   wire [4:0] tx_vec;
   wire [2:0] rx_vec, corr_vec;
   loop_gain_t freq_corr_gain, ook_thresh_gain;
   int err_total = 0, num_checks = 0, cycles = 0;

   radio_cfg_regs i_radio_cfg_regs (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .preamble_found(preamble_found),
      .sync_found(sync_found), .preamble_match_zero(preamble_match_zero), .rx_restart(rx_restart),
      .if_bw_khz(if_bw_khz), .if_freq_khz(if_freq_khz), .tx_fsk(tx_vec[4]), .tx_gfsk(tx_vec[3]),
      .tx_ook(tx_vec[2]), .tx_carrier(tx_vec[1]), .tx_mod_reserved(tx_vec[0]), .rx_fsk(rx_vec[2]),
      .rx_ook(rx_vec[1]), .rx_demod_reserved(rx_vec[0]), .freq_corr_enable(corr_vec[2]),
      .freq_corr_update(corr_vec[1]), .freq_corr_frozen(corr_vec[0]), .freq_corr_gain(freq_corr_gain),
      .ook_thresh_gain(ook_thresh_gain));

   // ------------------------------------------------------------
   // clock, hang guard and verdict
   // ------------------------------------------------------------
   initial begin
      forever #4 aclk = ~aclk;
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test

   // cut a hung handshake short
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask : chk

   // ------------------------------------------------------------
   // axi4-lite master: hold each channel until its own ready
   // ------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
      fork
         begin do @(posedge aclk); while (!awready); awvalid <= 1'h0; end
         begin do @(posedge aclk); while (!wready); wvalid <= 1'h0; end
      join
      while (!bvalid) @(posedge aclk);
      bready <= 1'h0;
      chk("bresp", r, bresp);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      while (!rvalid) @(posedge aclk);
      rready <= 1'h0;
      chk("rresp", r, rresp);
      chk("rdata", d, rdata);
   endtask : rd

   // decoded outputs and gains settle a few edges after the write answer
   task automatic settle;
      repeat (3) @(posedge aclk);
      #1;
   endtask : settle

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rd(A_BW, {24'h0, `BW_MOD_RST}, `RESP_OKAY);
      rd(A_MODE, {24'h0, `CORR_MODE_RST}, `RESP_OKAY);
      rd(A_GAIN, {24'h0, `CORR_GAIN_RST}, `RESP_OKAY);
      chk("gain", {16'h0008, 16'h0080}, freq_corr_gain);
      chk("corr", 3'h6, corr_vec);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_bw;
      logic [8:0] tab [4] = '{9'h064, 9'h096, 9'h0c8, 9'h12c};
      for (int i = 0; i < 4; i++) begin
         wr(A_BW, {24'h0, i[1:0], 6'h00}, 4'h1, `RESP_OKAY);
         settle();
         chk("if_bw", tab[i], if_bw_khz);
         chk("if_freq", (i == 3) ? 9'h12c : 9'h0c8, if_freq_khz);
      end
      $display("t_bw done");
   endtask : t_bw

   task automatic t_codes;
      for (int i = 0; i < 8; i++) begin
         wr(A_BW, {24'h0, 2'h0, i[2:0], i[2:0]}, 4'h1, `RESP_OKAY);
         settle();
         chk("tx_dec", (i < 4) ? (5'h10 >> i) : 5'h01, tx_vec);
         chk("rx_dec", (i == 0) ? 3'h4 : (i == 2) ? 3'h2 : 3'h1, rx_vec);
         rd(A_BW, {24'h0, 2'h0, i[2:0], i[2:0]}, `RESP_OKAY);
      end
      $display("t_codes done");
   endtask : t_codes

   task automatic t_gain;
      wr(A_BW, 32'h0, 4'h1, `RESP_OKAY);
      for (int p = 0; p < 16; p++) begin
         wr(A_GAIN, {24'h0, p[3:0], ~p[3:0]}, 4'h1, `RESP_OKAY);
         settle();
         chk("fc_gain", {16'h1 << p, 16'h1 << (15 - p)}, freq_corr_gain);
         chk("ook_gain", 32'h0, ook_thresh_gain);
      end
      wr(A_BW, 32'h02, 4'h1, `RESP_OKAY);
      settle();
      chk("fc_gain", 32'h0, freq_corr_gain);
      chk("ook_gain", {16'h8000, 16'h0001}, ook_thresh_gain);
      $display("t_gain done");
   endtask : t_gain

   task automatic t_bus;
      rd(12'h400, 32'h0, `RESP_SLVERR);
      wr(12'h400, 32'hff, 4'h1, `RESP_SLVERR);
      wr(A_GAIN, 32'haa, 4'h0, `RESP_OKAY);
      rd(A_GAIN, 32'hf0, `RESP_OKAY);
      wr(A_GAIN, 32'hffffff37, 4'h1, `RESP_OKAY);
      rd(A_GAIN, 32'h37, `RESP_OKAY);
      $display("t_bus done");
   endtask : t_bus

   // one detector pulse, then the loop outputs a settled edge later
   task automatic pulse(input logic [6:0] v);
      @(posedge aclk);
      preamble_match_zero <= v[6]; preamble_found <= v[5]; sync_found <= v[4]; rx_restart <= v[3];
      @(posedge aclk);
      {preamble_found, sync_found, rx_restart} <= 3'h0;
      @(posedge aclk);
      #1;
      chk("corr", v[2:0], corr_vec);
   endtask : pulse

   task automatic t_lock;
      logic [2:0] tab [4] = '{3'h6, 3'h0, 3'h4, 3'h6};
      logic [6:0] seq [5] = '{7'h16, 7'h55, 7'h4e, 7'h25, 7'h2d};
      for (int m = 0; m < 4; m++) begin
         wr(A_MODE, {24'h0, 6'h02, m[1:0]}, 4'h1, `RESP_OKAY);
         settle();
         chk("corr", tab[m], corr_vec);
      end
      rd(A_STAT, 32'h30, `RESP_OKAY);
      for (int k = 0; k < 5; k++) pulse(seq[k]);
      rd(A_STAT, 32'h11, `RESP_OKAY);
      // status is read only: a write is answered but leaves it alone
      wr(A_STAT, 32'hff, 4'h1, `RESP_OKAY);
      rd(A_STAT, 32'h11, `RESP_OKAY);
      wr(A_MODE, 32'h0a, 4'h1, `RESP_OKAY);
      settle();
      chk("corr", 3'h4, corr_vec);
      rd(A_STAT, 32'h10, `RESP_OKAY);
      $display("t_lock done");
   endtask : t_lock

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset();
      t_bw();
      t_codes();
      t_gain();
      t_bus();
      t_lock();
      finish_test();
   end
endmodule : tb_radio_modem_afc_config_regs

`default_nettype wire
